// ### rtl/pbe_consts.svh
// Timing, width and field constants of the parallel block encoder
`ifndef PBE_CONSTS_SVH
`define PBE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Symbol and code geometry
// ----------------------------------------------------------------------------
`define PBE_SYM_W 16
`define PBE_MSG_W 12
`define PBE_DATA_SYMS 28
`define PBE_CODE_SYMS 30
`define PBE_PAR_W 36
`define PBE_LAT 4
`define PBE_GEN_POLY 36'h0_0000_0c01

// ----------------------------------------------------------------------------
// Parity packing: upper and middle slices go to the two parity symbols,
// the lowest nibble rides in the don't-care bits of the last data symbol
// ----------------------------------------------------------------------------
`define PBE_PAR_HI_MSB 35
`define PBE_PAR_HI_LSB 20
`define PBE_PAR_MID_MSB 19
`define PBE_PAR_MID_LSB 4
`define PBE_PAR_LO_MSB 3

// ----------------------------------------------------------------------------
// Source pacing, in clocks from one start pulse to the next
// ----------------------------------------------------------------------------
`define PBE_START_B2B 34
`define PBE_START_GAP_MIN 39
`define PBE_CNT_W 6

`endif

// ### rtl/pbe_pkg.sv
// Types shared by both ends of the parallel block encoder
`default_nettype none

package pbe_pkg;

    // ------------------------------------------------------------------------
    // Input side state of the encoder
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        PBE_IN_IDLE,
        PBE_IN_LOAD
    } pbe_in_state_type;

    // ------------------------------------------------------------------------
    // State of the upstream source
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PBE_SRC_IDLE,
        PBE_SRC_SEND,
        PBE_SRC_WAIT
    } pbe_src_state_type;

endpackage : pbe_pkg

`default_nettype wire

// ### rtl/pbe_if.sv
// Link between the block source and the encoder
`timescale 1ns/1ns
`default_nettype none
`include "pbe_consts.svh"

interface pbe_if;
    logic start;
    logic [`PBE_SYM_W-1:0] data;
    logic [`PBE_SYM_W-1:0] code;
    logic code_ce;

    // Encoder end
    modport enc (
        input start,
        input data,
        output code,
        output code_ce
    );

    // Upstream source and downstream sink end
    modport src (
        output start,
        output data,
        input code,
        input code_ce
    );
endinterface : pbe_if

`default_nettype wire

// ### rtl/pbe_parity.sv
// Parity accumulator: remainder of the message modulo the generator
`timescale 1ns/1ns
`default_nettype none
`include "pbe_consts.svh"

module pbe_parity #(
    parameter int PAR_W = `PBE_PAR_W,
    parameter int MSG_W = `PBE_MSG_W,
    parameter logic [PAR_W-1:0] GEN_POLY = `PBE_GEN_POLY
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [MSG_W-1:0] msg_i,
    output logic [PAR_W-1:0] par_o,
    output logic [PAR_W-1:0] par_nxt_o
);

    // ------------------------------------------------------------------------
    // One symbol of message bits, MSB first, through the divider
    // ------------------------------------------------------------------------
    function automatic logic [PAR_W-1:0] pbe_div_step(
        input logic [PAR_W-1:0] rem,
        input logic [MSG_W-1:0] msg
    );
        logic [PAR_W-1:0] r;
        logic fb;
        r = rem;
        for (int i = MSG_W - 1; i >= 0; i--) begin
            fb = msg[i] ^ r[PAR_W-1];
            r = {r[PAR_W-2:0], 1'b0} ^ (fb ? GEN_POLY : '0);
        end
        return r;
    endfunction : pbe_div_step

    // Clearing and loading in one cycle starts a block from a zero remainder
    always_comb begin
        par_nxt_o = pbe_div_step(clr_i ? '0 : par_o, msg_i);
    end

    // Remainder register, asynchronously cleared
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            par_o <= '0;
        end else if (en_i) begin
            par_o <= par_nxt_o;
        end else if (clr_i) begin
            par_o <= '0;
        end
    end

endmodule : pbe_parity

`default_nettype wire

// ### rtl/pbe_encoder.sv
// Encoder end: passes data through and appends the parity symbols
`timescale 1ns/1ns
`default_nettype none
`include "pbe_consts.svh"

// ----------------------------------------------------------------------------
// Function
// - Clear forces all state immediately, holds
// - All state on rising edge, one clock
// - Start strobe begins a new encoding run
// - Source pulses start exactly one cycle
// - First symbol arrives cycle after start
// - One symbol per clock, 28 per block
// - Only 12 MSBs enter the parity
// - Append 36 parity bits, 30 symbols
// - Data passes unchanged except last symbol's low nibble
// - Parity symbols follow the last data
// - Four clocks from input to output
// - Output valid high exactly 30 cycles
// - Back-to-back start aligns with last parity
// - Otherwise start five clocks after parity
// - Input block gap rules, continuous or not
// ----------------------------------------------------------------------------

module pbe_encoder #(
    parameter int SYM_W = `PBE_SYM_W,
    parameter int MSG_W = `PBE_MSG_W,
    parameter int DATA_SYMS = `PBE_DATA_SYMS,
    parameter int PAR_W = `PBE_PAR_W,
    parameter int LAT = `PBE_LAT,
    parameter logic [PAR_W-1:0] GEN_POLY = `PBE_GEN_POLY
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    pbe_if.enc lnk,
    output logic busy_o,
    output logic blk_done_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam int CNT_W = `PBE_CNT_W;
    localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(DATA_SYMS - 1);
    localparam int DLY = LAT - 1;

    pbe_pkg::pbe_in_state_type in_state_r;
    logic [CNT_W-1:0] in_cnt_r;
    logic in_vld;
    logic in_last;
    logic [PAR_W-1:0] par_cur;
    logic [PAR_W-1:0] par_nxt;
    logic [PAR_W-1:0] par_hold_r;
    logic [SYM_W-1:0] dly_data_r [DLY];
    logic dly_vld_r [DLY];
    logic dly_last_r [DLY];
    logic [1:0] par_step_r;
    logic [SYM_W-1:0] code_r;
    logic code_ce_r;
    logic busy_r;
    logic done_r;

    // ------------------------------------------------------------------------
    // Input sequencing
    // ------------------------------------------------------------------------

    // A symbol is taken on every clock of a loading run
    assign in_vld = (in_state_r == pbe_pkg::PBE_IN_LOAD);
    assign in_last = in_vld && (in_cnt_r == LAST_IDX);

    // Start wins over a run in progress, so a late strobe never gets lost
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_state_r <= pbe_pkg::PBE_IN_IDLE;
            in_cnt_r <= '0;
        end else begin
            case (in_state_r)
                pbe_pkg::PBE_IN_IDLE: begin
                    in_cnt_r <= '0;
                    if (lnk.start) begin
                        in_state_r <= pbe_pkg::PBE_IN_LOAD;
                    end
                end
                pbe_pkg::PBE_IN_LOAD: begin
                    if (lnk.start) begin
                        in_cnt_r <= '0;
                    end else if (in_last) begin
                        in_state_r <= pbe_pkg::PBE_IN_IDLE;
                        in_cnt_r <= '0;
                    end else begin
                        in_cnt_r <= in_cnt_r + CNT_W'(1);
                    end
                end
                default: begin
                    in_state_r <= pbe_pkg::PBE_IN_IDLE;
                    in_cnt_r <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Parity unit
    // ------------------------------------------------------------------------

    // Low bits of each symbol never reach the divider
    pbe_parity #(
        .PAR_W(PAR_W),
        .MSG_W(MSG_W),
        .GEN_POLY(GEN_POLY)
    ) u_parity (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .clr_i(lnk.start),
        .en_i(in_vld),
        .msg_i(lnk.data[SYM_W-1 -: MSG_W]),
        .par_o(par_cur),
        .par_nxt_o(par_nxt)
    );

    // Snapshot on the last symbol frees the divider for the next block
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            par_hold_r <= '0;
        end else if (in_last) begin
            par_hold_r <= par_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Data delay line, output flop makes the last stage
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DLY; g++) begin : g_dly
            if (g == 0) begin : g_head
                // First stage samples the link; no stage below it to index
                always_ff @(posedge clk_i or negedge rstn_i) begin
                    if (!rstn_i) begin
                        dly_data_r[g] <= '0;
                        dly_vld_r[g] <= 1'b0;
                        dly_last_r[g] <= 1'b0;
                    end else begin
                        dly_data_r[g] <= lnk.data;
                        dly_vld_r[g] <= in_vld;
                        dly_last_r[g] <= in_last;
                    end
                end
            end else begin : g_tail
                // Later stages shift the previous one
                always_ff @(posedge clk_i or negedge rstn_i) begin
                    if (!rstn_i) begin
                        dly_data_r[g] <= '0;
                        dly_vld_r[g] <= 1'b0;
                        dly_last_r[g] <= 1'b0;
                    end else begin
                        dly_data_r[g] <= dly_data_r[g-1];
                        dly_vld_r[g] <= dly_vld_r[g-1];
                        dly_last_r[g] <= dly_last_r[g-1];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Output mux: data symbols, then the two parity symbols
    // ------------------------------------------------------------------------

    // Parity step 1 and 2 follow the last data symbol directly
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            par_step_r <= 2'h0;
        end else if (dly_last_r[DLY-1]) begin
            par_step_r <= 2'h1;
        end else if (par_step_r == 2'h1) begin
            par_step_r <= 2'h2;
        end else begin
            par_step_r <= 2'h0;
        end
    end

    // The lowest parity nibble uses the ignored low bits of the last symbol,
    // since two full symbols only carry 32 of the 36 parity bits
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            code_r <= '0;
            code_ce_r <= 1'b0;
        end else if (dly_vld_r[DLY-1]) begin
            code_r <= dly_data_r[DLY-1];
            if (dly_last_r[DLY-1]) begin
                code_r[`PBE_PAR_LO_MSB:0] <= par_hold_r[`PBE_PAR_LO_MSB:0];
            end
            code_ce_r <= 1'b1;
        end else if (par_step_r == 2'h1) begin
            code_r <= par_hold_r[`PBE_PAR_HI_MSB:`PBE_PAR_HI_LSB];
            code_ce_r <= 1'b1;
        end else if (par_step_r == 2'h2) begin
            code_r <= par_hold_r[`PBE_PAR_MID_MSB:`PBE_PAR_MID_LSB];
            code_ce_r <= 1'b1;
        end else begin
            code_r <= '0;
            code_ce_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // User-side status
    // ------------------------------------------------------------------------

    // Busy spans input run, delay line and parity symbols
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            busy_r <= in_vld || lnk.start || dly_vld_r[0] || dly_vld_r[DLY-1]
                || (par_step_r != 2'h0) || code_ce_r;
            done_r <= (par_step_r == 2'h2);
        end
    end

    assign lnk.code = code_r;
    assign lnk.code_ce = code_ce_r;
    assign busy_o = busy_r;
    assign blk_done_o = done_r;

    // Note: the parity remainder par_cur is only seen through par_nxt
    // and the snapshot; it is kept as a port for visibility in waves
    logic unused_par;
    assign unused_par = ^par_cur;

endmodule : pbe_encoder

`default_nettype wire

// ### rtl/pbe_source.sv
// Far end: paces data blocks into the encoder and collects codewords
`timescale 1ns/1ns
`default_nettype none
`include "pbe_consts.svh"

module pbe_source #(
    parameter int SYM_W = `PBE_SYM_W,
    parameter int DATA_SYMS = `PBE_DATA_SYMS,
    parameter int CODE_SYMS = `PBE_CODE_SYMS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic send_i,
    input wire logic b2b_i,
    input wire logic [SYM_W-1:0] usr_data_i,
    output logic usr_rd_o,
    output logic [SYM_W-1:0] rx_code_o,
    output logic rx_vld_o,
    output logic rx_last_o,
    pbe_if.src lnk
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam int CNT_W = `PBE_CNT_W;
    localparam logic [CNT_W-1:0] SEND_LAST = CNT_W'(DATA_SYMS);
    localparam logic [CNT_W-1:0] SPC_B2B = CNT_W'(`PBE_START_B2B);
    localparam logic [CNT_W-1:0] SPC_GAP = CNT_W'(`PBE_START_GAP_MIN);
    localparam logic [CNT_W-1:0] RX_LAST = CNT_W'(CODE_SYMS - 1);

    pbe_pkg::pbe_src_state_type st_r;
    logic [CNT_W-1:0] cyc_r;
    logic start_r;
    logic [SYM_W-1:0] data_r;
    logic rd_r;
    logic go;
    logic [CNT_W-1:0] rx_cnt_r;
    logic [SYM_W-1:0] rx_code_r;
    logic rx_vld_r;
    logic rx_last_r;

    // Next start may issue on exact back-to-back spacing or after the gap
    assign go = send_i && ((st_r == pbe_pkg::PBE_SRC_IDLE)
        || ((st_r == pbe_pkg::PBE_SRC_WAIT) && (b2b_i ? (cyc_r == SPC_B2B - CNT_W'(1))
        : (cyc_r >= SPC_GAP - CNT_W'(1)))));

    // ------------------------------------------------------------------------
    // Block sequencer; cyc_r counts clocks since the start pulse
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= pbe_pkg::PBE_SRC_IDLE;
            cyc_r <= '0;
        end else begin
            case (st_r)
                pbe_pkg::PBE_SRC_IDLE: begin
                    cyc_r <= '0;
                    if (go) begin
                        st_r <= pbe_pkg::PBE_SRC_SEND;
                    end
                end
                pbe_pkg::PBE_SRC_SEND: begin
                    cyc_r <= cyc_r + CNT_W'(1);
                    if (cyc_r == SEND_LAST - CNT_W'(1)) begin
                        st_r <= pbe_pkg::PBE_SRC_WAIT;
                    end
                end
                pbe_pkg::PBE_SRC_WAIT: begin
                    if (go) begin
                        st_r <= pbe_pkg::PBE_SRC_SEND;
                        cyc_r <= '0;
                    end else if (cyc_r >= SPC_GAP - CNT_W'(1)) begin
                        st_r <= pbe_pkg::PBE_SRC_IDLE;
                    end else begin
                        cyc_r <= cyc_r + CNT_W'(1);
                    end
                end
                default: begin
                    st_r <= pbe_pkg::PBE_SRC_IDLE;
                    cyc_r <= '0;
                end
            endcase
        end
    end

    // Start is one cycle; the read strobe rises with it so every word taken
    // from the user is acknowledged in the cycle that it is latched
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_r <= 1'b0;
            rd_r <= 1'b0;
            data_r <= '0;
        end else begin
            start_r <= go;
            rd_r <= go || ((st_r == pbe_pkg::PBE_SRC_SEND)
                && (cyc_r < SEND_LAST - CNT_W'(1)));
            data_r <= rd_r ? usr_data_i : '0;
        end
    end

    // ------------------------------------------------------------------------
    // Codeword sink: counts the 30 symbols of each valid run
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_cnt_r <= '0;
            rx_code_r <= '0;
            rx_vld_r <= 1'b0;
            rx_last_r <= 1'b0;
        end else begin
            rx_vld_r <= lnk.code_ce;
            rx_code_r <= lnk.code;
            rx_last_r <= lnk.code_ce && (rx_cnt_r == RX_LAST);
            if (!lnk.code_ce || rx_cnt_r == RX_LAST) begin
                rx_cnt_r <= '0;
            end else begin
                rx_cnt_r <= rx_cnt_r + CNT_W'(1);
            end
        end
    end

    assign lnk.start = start_r;
    assign lnk.data = data_r;
    assign usr_rd_o = rd_r;
    assign rx_code_o = rx_code_r;
    assign rx_vld_o = rx_vld_r;
    assign rx_last_o = rx_last_r;

endmodule : pbe_source

`default_nettype wire

// ### verification/pbe_link_checker.sv
// Timing checks on the link between the block source and the encoder
`timescale 1ns/1ns
`default_nettype none
`include "pbe_consts.svh"

module pbe_link_checker (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [`PBE_SYM_W-1:0] data_i,
    input wire logic [`PBE_SYM_W-1:0] code_i,
    input wire logic code_ce_i,
    input wire logic busy_i,
    input wire logic blk_done_i
);
    // ------------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------------
    logic [5:0] ce_run_r;
    logic [5:0] gap_r;

    // Run length of the valid strobe, and clocks since the last start
    // (saturating, so a long idle never looks like a short spacing)
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ce_run_r <= 6'h00;
            gap_r <= 6'h3f;
        end else begin
            ce_run_r <= code_ce_i ? ce_run_r + 6'h01 : 6'h00;
            gap_r <= start_i ? 6'h00 : ((gap_r == 6'h3f) ? gap_r : gap_r + 6'h01);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_start_pulse: assert property (start_i |=> !start_i)
        else $error("start held longer than one cycle");
    a_start_spacing: assert property (
        start_i |-> gap_r == 6'h21 || gap_r >= 6'h26)
        else $error("start spacing neither aligned nor long enough");
    a_first_out_lat: assert property (start_i |-> ##5 $rose(code_ce_i))
        else $error("first code symbol not five cycles after start");
    a_ce_has_cause: assert property ($rose(code_ce_i) |-> $past(start_i, 5))
        else $error("code valid rose without a start");
    a_ce_max_len: assert property (code_ce_i |-> ce_run_r < 6'h1e)
        else $error("code valid longer than a codeword");
    a_ce_full_len: assert property ($fell(code_ce_i) |-> ce_run_r == 6'h1e)
        else $error("code valid shorter than a codeword");
    // Done marks the cycle of the last parity symbol itself
    a_done_on_end: assert property ($fell(code_ce_i) |-> $past(blk_done_i))
        else $error("block done missing with last parity");
    a_done_only_end: assert property (blk_done_i |-> code_ce_i ##1 !code_ce_i)
        else $error("block done away from codeword end");
    a_busy_in_run: assert property (code_ce_i |-> busy_i)
        else $error("busy low while codeword is output");
    a_data_passes: assert property (
        code_ce_i && ce_run_r < 6'h1c |-> code_i[15:4] == $past(data_i[15:4], 4)
        && (ce_run_r == 6'h1b || code_i[3:0] == $past(data_i[3:0], 4)))
        else $error("data symbol not passed through unchanged");
endmodule : pbe_link_checker

`default_nettype wire

// ### verification/parallel_bch_block_encoder_bench.sv
// Self-checking bench: source and encoder face each other over the link
`timescale 1ns/1ns
`default_nettype none
`include "pbe_consts.svh"

module parallel_bch_block_encoder_bench;
    localparam int NB = 6;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic send_i = 1'b0;
    logic b2b_i = 1'b0;
    logic [15:0] usr_data_i = 16'h0000;
    logic usr_rd_o;
    logic [15:0] rx_code_o;
    logic rx_vld_o;
    logic rx_last_o;
    logic busy_o;
    logic blk_done_o;
    logic [15:0] mem [NB*28];
    logic [15:0] exp_q [NB*30];
    logic [35:0] p;
    int n_errors = 0;
    int samples_checked = 0;
    int k = 0;
    int r = 0;
    int cyc = 0;

    pbe_if pbe_if_i ();
    pbe_encoder pbe_encoder_i (.clk_i(clk_i), .rstn_i(rstn_i), .lnk(pbe_if_i),
        .busy_o(busy_o), .blk_done_o(blk_done_o));
    pbe_source pbe_source_i (.clk_i(clk_i), .rstn_i(rstn_i), .send_i(send_i),
        .b2b_i(b2b_i), .usr_data_i(usr_data_i), .usr_rd_o(usr_rd_o),
        .rx_code_o(rx_code_o), .rx_vld_o(rx_vld_o), .rx_last_o(rx_last_o),
        .lnk(pbe_if_i));
    pbe_link_checker pbe_link_checker_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .start_i(pbe_if_i.start), .data_i(pbe_if_i.data), .code_i(pbe_if_i.code),
        .code_ce_i(pbe_if_i.code_ce), .busy_i(busy_o), .blk_done_i(blk_done_o));

    // ------------------------------------------------------------------------
    // Clock, user data and codeword monitor
    // ------------------------------------------------------------------------
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    // Offer the next word once the source has taken the current one
    always @(posedge clk_i) begin
        if (usr_rd_o === 1'b1) begin
            k = k + 1;
        end
        #1 usr_data_i = mem[k % (NB*28)];
    end

    // Every received symbol is compared in order against the table
    always @(posedge clk_i) begin
        if (rx_vld_o === 1'b1) begin
            check(rx_code_o, exp_q[r % (NB*30)]);
            check(16'(rx_last_o), 16'(r % 30 == 29));
            r = r + 1;
        end
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic finish_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // Remainder over the 12 upper bits of each word, first bit first;
    // the low nibble is skipped so a design that uses it disagrees
    function automatic logic [35:0] par_of(input int b);
        logic [35:0] rem;
        logic fb;
        rem = 36'h0;
        for (int i = 0; i < 28; i++) begin
            for (int j = 15; j > 3; j--) begin
                fb = mem[b*28+i][j] ^ rem[35];
                rem = {rem[34:0], 1'b0} ^ (fb ? `PBE_GEN_POLY : 36'h0);
            end
        end
        return rem;
    endfunction : par_of

    // Ask for n blocks with the given spacing and wait for their codewords
    task automatic run(input logic b2b, input int n);
        int t0;
        int w;
        int r_end;
        r_end = r + n * 30;
        @(posedge clk_i);
        #1 b2b_i = b2b;
        send_i = 1'b1;
        for (int s = 0; s < n; s++) begin
            w = 0;
            do begin
                @(posedge clk_i);
                #1 w++;
            end while (pbe_if_i.start !== 1'b1 && w < 100);
            if (s > 0) begin
                check(16'(b2b ? (cyc - t0 == 34) : (cyc - t0 >= 39)),
                    16'h0001);
            end
            t0 = cyc;
        end
        send_i = 1'b0;
        w = 0;
        while (r < r_end && w < 2000) begin
            @(posedge clk_i);
            #1 w++;
        end
        check(16'(r), 16'(r_end));
    endtask : run

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        // Block 1 differs from block 0 only in the ignored low nibbles
        for (int b = 0; b < NB; b++) begin
            for (int i = 0; i < 28; i++) begin
                mem[b*28+i] = 16'h0a5a + 16'(b) * 16'h02c1 + 16'(i) * 16'h1357;
                if (b == 1) mem[b*28+i] = mem[i] ^ 16'h000f;
                if (b == 2) mem[b*28+i] = 16'hffff;
                if (b == 3) mem[b*28+i] = 16'h0000;
            end
            p = par_of(b);
            for (int i = 0; i < 28; i++) begin
                exp_q[b*30+i] = mem[b*28+i];
            end
            exp_q[b*30+27][3:0] = p[3:0];
            exp_q[b*30+28] = p[35:20];
            exp_q[b*30+29] = p[19:4];
        end
        repeat (20) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        run(1'b1, 3);
        run(1'b0, 2);
        // Clear in mid-codeword: outputs drop at once and stay down
        send_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1 check(16'(pbe_if_i.code_ce), 16'h0001);
        rstn_i = 1'b0;
        send_i = 1'b0;
        k = 5 * 28;
        #2 check(16'({pbe_if_i.code_ce, busy_o, blk_done_o, rx_vld_o}), 16'h0000);
        repeat (2) @(posedge clk_i);
        #1 check(pbe_if_i.code, 16'h0000);
        check(16'({pbe_if_i.code_ce, busy_o}), 16'h0000);
        r = 5 * 30;
        rstn_i = 1'b1;
        run(1'b0, 1);
        finish_test();
    end

    // Watchdog: the whole run needs well under a thousand clocks
    initial begin
        #50000;
        n_errors++;
        finish_test();
    end
endmodule : parallel_bch_block_encoder_bench

`default_nettype wire
